// File: acr_defines.svh
/*
  register offsets, field positions, reset values and timing counts of the converter
  configuration bank. assumes inclusion by bare name from the modules.
*/
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

`define ACR_OFS_HIGH_PERF_TUNING_A   8'h02
`define ACR_OFS_POWER_AND_LVDS_DRIVE 8'h45
`define ACR_OFS_CHAN_B_HIGH_FREQ     8'h4a
`define ACR_OFS_CHAN_A_HIGH_FREQ     8'h58
`define ACR_OFS_CHAN_A_PEDESTAL      8'hbf
`define ACR_OFS_CHAN_B_PEDESTAL      8'hc1
`define ACR_OFS_OFFSET_LOOP_CONTROL  8'hcf
`define ACR_OFS_SLOW_MODE_MASTER     8'hef
`define ACR_OFS_SWING_CONTROL_ENABLE 8'hf1
`define ACR_OFS_CHAN_A_SLOW_MODE     8'hf2
`define ACR_OFS_LOOP_ENABLE          8'h3d
`define ACR_OFS_STATUS               8'h60

`define ACR_REG_RESET                8'h00
`define ACR_BIT_STANDBY              7
`define ACR_BIT_CLKOUT_DRIVE         6
`define ACR_BIT_FULL_PDN             2
`define ACR_BIT_FAST_INPUT           0
`define ACR_SHIFT_MSB                7
`define ACR_SHIFT_LSB                2
`define ACR_BIT_HOLD                 7
`define ACR_TAU_MSB                  5
`define ACR_TAU_LSB                  2
`define ACR_BIT_SLOW_MASTER          4
`define ACR_BIT_CHAN_A_SLOW          3
`define ACR_BIT_LOOP_ON              5
`define ACR_BIT_FAST_TUNING          6
`define ACR_SWING_ON                 2'b11

`define ACR_WAKE_TIME_US             50
`define ACR_CLK_MHZ                  50
`define ACR_WAKE_CYCLES              (`ACR_WAKE_TIME_US * `ACR_CLK_MHZ)

`endif

// File: acr_pkg.sv
/*
  types of the converter configuration bank.
  assumes acr_defines.svh is on the include path.
*/
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_PWR_RUN   = 2'b00,
    ACR_PWR_STANDBY_REQUEST  = 2'b01,
    ACR_PWR_OFF   = 2'b10,
    ACR_PWR_WAKE  = 2'b11
  } acr_pwr_t;
endpackage

// File: acr_offset_loop.sv
/*
  one channel offset correction loop: first-order estimate of the input mean,
  correction drives output toward midcode plus a signed pedestal.
  assumes samples arrive as offset binary on the same clock.
*/
`include "acr_defines.svh"
module acr_offset_loop #(
  parameter int WIDTH = 14
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_loop_on,
  input  wire logic             i_hold,
  input  wire logic [3:0]       i_tau,
  input  wire logic [5:0]       i_shift,
  input  wire logic [WIDTH-1:0] i_sample,
  output logic      [WIDTH-1:0] o_sample
);
  // integer part of the estimate is WIDTH+2 bits so a negative offset keeps its sign
  localparam int ACC = WIDTH + 18;
  localparam logic [WIDTH-1:0] MID = {1'b1, {(WIDTH-1){1'b0}}};
  logic signed [ACC-1:0]   est_reg;
  logic signed [ACC-1:0]   est_next;
  logic [WIDTH-1:0]        out_reg;
  wire  signed [WIDTH+1:0] err;
  wire  signed [WIDTH+1:0] est_int;
  wire  signed [WIDTH+1:0] target;
  wire  signed [WIDTH+1:0] corrected;
  wire  signed [WIDTH+1:0] clamped;

  // error of the corrected output against midcode plus pedestal
  assign target    = $signed({2'b00, MID}) + $signed({{(WIDTH-4){i_shift[5]}}, i_shift});
  assign est_int   = est_reg[ACC-1:16];
  assign corrected = $signed({2'b00, i_sample}) - est_int;
  assign err       = corrected - target;
  // time constant sets the loop gain as 2 to the minus tau, about 2 to the tau cycles
  assign est_next  = i_hold ? est_reg : est_reg + ((ACC'(err) <<< 16) >>> i_tau);
  assign clamped   = corrected < 0 ? '0 :
                     corrected > $signed({2'b00, {WIDTH{1'b1}}}) ?
                     $signed({2'b00, {WIDTH{1'b1}}}) : corrected;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_loop_on) begin
      est_reg <= '0;
    end else begin
      est_reg <= est_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      out_reg <= '0;
    end else begin
      out_reg <= i_loop_on ? clamped[WIDTH-1:0] : i_sample;
    end
  end

  assign o_sample = out_reg;
endmodule

// File: acr_bank.sv
/*
  configuration register bank of a dual channel converter: power, input mode,
  pedestal, offset loop, slow mode, swing enable and tuning bits over classic wishbone.
  assumes a synchronous wishbone master on i_ref_clk and samples on the same clock.
*/
// Local design decision: register access over Wishbone.
// Functional notes
// - standby bit puts both channels in standby; wake takes about 50 us.
// - global power-down turns off channels and output buffers; clear restores.
// - channel b fast input bit selects high input frequency mode when set.
// - channel a fast input bit selects high input frequency mode when set.
// - enabled offset loop converges output to midcode plus pedestal.
// - channel a pedestal bits 7:2 are six-bit two's complement offset.
// - channel b pedestal uses same encoding, independent of channel a.
// - hold bit freezes estimate and keeps applying last correction.
// - bits 5:2 set offset loop time constant as 2 to that value in clock cycles.
// - slow master bit hands slow mode to channel bits; clear disables.
// - channel a slow bit enables slow mode; host sets master first.
// - swing enable field 00 off, 11 on; host avoids 01 and 10.
// - all writable registers reset to zero; status reads 0x0f after reset.
`include "acr_defines.svh"
module acr_bank
  import acr_pkg::*;
#(
  parameter int WIDTH       = 14,
  parameter int WAKE_CYCLES = `ACR_WAKE_CYCLES
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [7:0]       i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic      [31:0]      o_wb_dat,
  output logic                  o_wb_ack,
  input  wire logic [WIDTH-1:0] i_chan_a_sample,
  input  wire logic [WIDTH-1:0] i_chan_b_sample,
  output logic      [WIDTH-1:0] o_chan_a_sample,
  output logic      [WIDTH-1:0] o_chan_b_sample,
  output logic                  o_chan_a_power_on,
  output logic                  o_chan_b_power_on,
  output logic                  o_out_buffers_on,
  output logic                  o_ready,
  output logic                  o_chan_a_fast_input_mode,
  output logic                  o_chan_b_fast_input_mode,
  output logic                  o_chan_a_slow_on,
  output logic                  o_swing_ctrl_on,
  output logic                  o_clock_out_drive_level,
  output logic                  o_fast_sample_tuning_bit
);
  logic [7:0] power_and_lvds_drive_reg;
  logic [7:0] chan_b_high_freq_reg;
  logic [7:0] chan_a_high_freq_reg;
  logic [7:0] chan_a_pedestal_reg;
  logic [7:0] chan_b_pedestal_reg;
  logic [7:0] offset_loop_control_reg;
  logic [7:0] slow_mode_master_reg;
  logic [7:0] swing_control_enable_reg;
  logic [7:0] chan_a_slow_mode_reg;
  logic [7:0] high_perf_tuning_a_reg;
  logic [7:0] loop_enable_reg;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  acr_pwr_t    pwr_reg;
  acr_pwr_t    pwr_next;
  logic [31:0] wake_cnt_reg;
  logic [31:0] wake_cnt_next;
  logic        a_on_reg;
  logic        b_on_reg;
  logic        buf_on_reg;
  logic        ready_reg;
  logic        a_fast_reg;
  logic        b_fast_reg;
  logic        a_slow_reg;
  logic        swing_reg;
  logic        drive_reg;
  logic        tuning_reg;

  wire        req      = i_wb_cyc && i_wb_stb && !ack_reg;
  wire        wr       = req && i_wb_we && i_wb_sel[0];
  wire [7:0]  wd       = i_wb_dat[7:0];
  wire        sel_pwr  = i_wb_adr == `ACR_OFS_POWER_AND_LVDS_DRIVE;
  wire        sel_bhf  = i_wb_adr == `ACR_OFS_CHAN_B_HIGH_FREQ;
  wire        sel_ahf  = i_wb_adr == `ACR_OFS_CHAN_A_HIGH_FREQ;
  wire        sel_aped = i_wb_adr == `ACR_OFS_CHAN_A_PEDESTAL;
  wire        sel_bped = i_wb_adr == `ACR_OFS_CHAN_B_PEDESTAL;
  wire        sel_loop = i_wb_adr == `ACR_OFS_OFFSET_LOOP_CONTROL;
  wire        sel_slm  = i_wb_adr == `ACR_OFS_SLOW_MODE_MASTER;
  wire        sel_swg  = i_wb_adr == `ACR_OFS_SWING_CONTROL_ENABLE;
  wire        sel_asl  = i_wb_adr == `ACR_OFS_CHAN_A_SLOW_MODE;
  wire        sel_hp   = i_wb_adr == `ACR_OFS_HIGH_PERF_TUNING_A;
  wire        sel_en   = i_wb_adr == `ACR_OFS_LOOP_ENABLE;
  wire        sel_st   = i_wb_adr == `ACR_OFS_STATUS;
  wire        standby  = power_and_lvds_drive_reg[`ACR_BIT_STANDBY];
  wire        full_pdn = power_and_lvds_drive_reg[`ACR_BIT_FULL_PDN];
  wire        loop_on  = loop_enable_reg[`ACR_BIT_LOOP_ON];
  wire        hold     = offset_loop_control_reg[`ACR_BIT_HOLD];
  wire [3:0]  tau      = offset_loop_control_reg[`ACR_TAU_MSB:`ACR_TAU_LSB];
  wire [5:0]  a_shift  = chan_a_pedestal_reg[`ACR_SHIFT_MSB:`ACR_SHIFT_LSB];
  wire [5:0]  b_shift  = chan_b_pedestal_reg[`ACR_SHIFT_MSB:`ACR_SHIFT_LSB];
  wire [7:0]  status   = {4'h0, ready_reg, buf_on_reg, b_on_reg, a_on_reg};
  wire [7:0]  rmux;

  // read decode; unmapped offsets read zero and still acknowledge
  assign rmux = sel_pwr  ? power_and_lvds_drive_reg :
                sel_bhf  ? chan_b_high_freq_reg :
                sel_ahf  ? chan_a_high_freq_reg :
                sel_aped ? chan_a_pedestal_reg :
                sel_bped ? chan_b_pedestal_reg :
                sel_loop ? offset_loop_control_reg :
                sel_slm  ? slow_mode_master_reg :
                sel_swg  ? swing_control_enable_reg :
                sel_asl  ? chan_a_slow_mode_reg :
                sel_hp   ? high_perf_tuning_a_reg :
                sel_en   ? loop_enable_reg :
                sel_st   ? status : 8'h00;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= req;
      rdata_reg <= req ? {24'h00_0000, rmux} : 32'h0000_0000;
    end
  end

  // register writes, all from a zero reset, effective immediately
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      power_and_lvds_drive_reg <= `ACR_REG_RESET;
      chan_b_high_freq_reg     <= `ACR_REG_RESET;
      chan_a_high_freq_reg     <= `ACR_REG_RESET;
      chan_a_pedestal_reg      <= `ACR_REG_RESET;
      chan_b_pedestal_reg      <= `ACR_REG_RESET;
      offset_loop_control_reg  <= `ACR_REG_RESET;
      slow_mode_master_reg     <= `ACR_REG_RESET;
      swing_control_enable_reg <= `ACR_REG_RESET;
      chan_a_slow_mode_reg     <= `ACR_REG_RESET;
      high_perf_tuning_a_reg   <= `ACR_REG_RESET;
      loop_enable_reg          <= `ACR_REG_RESET;
    end else if (wr) begin
      if (sel_pwr) begin
        power_and_lvds_drive_reg <= wd;
      end else if (sel_bhf) begin
        chan_b_high_freq_reg <= wd;
      end else if (sel_ahf) begin
        chan_a_high_freq_reg <= wd;
      end else if (sel_aped) begin
        chan_a_pedestal_reg <= wd;
      end else if (sel_bped) begin
        chan_b_pedestal_reg <= wd;
      end else if (sel_loop) begin
        offset_loop_control_reg <= wd;
      end else if (sel_slm) begin
        slow_mode_master_reg <= wd;
      end else if (sel_swg) begin
        swing_control_enable_reg <= wd;
      end else if (sel_asl) begin
        chan_a_slow_mode_reg <= wd;
      end else if (sel_hp) begin
        high_perf_tuning_a_reg <= wd;
      end else if (sel_en) begin
        loop_enable_reg <= wd;
      end
    end
  end

  // power sequencing: off wins over standby, wake counts down before ready
  always_comb begin
    pwr_next      = pwr_reg;
    wake_cnt_next = wake_cnt_reg;
    case (pwr_reg)
      ACR_PWR_RUN: begin
        if (full_pdn) begin
          pwr_next = ACR_PWR_OFF;
        end else if (standby) begin
          pwr_next = ACR_PWR_STANDBY_REQUEST;
        end
      end
      ACR_PWR_STANDBY_REQUEST, ACR_PWR_OFF: begin
        if (full_pdn) begin
          pwr_next = ACR_PWR_OFF;
        end else if (standby) begin
          pwr_next = ACR_PWR_STANDBY_REQUEST;
        end else begin
          pwr_next      = ACR_PWR_WAKE;
          wake_cnt_next = 32'(WAKE_CYCLES - 1);
        end
      end
      ACR_PWR_WAKE: begin
        if (full_pdn) begin
          pwr_next = ACR_PWR_OFF;
        end else if (standby) begin
          pwr_next = ACR_PWR_STANDBY_REQUEST;
        end else if (wake_cnt_reg == 32'h0000_0000) begin
          pwr_next = ACR_PWR_RUN;
        end else begin
          wake_cnt_next = wake_cnt_reg - 32'h0000_0001;
        end
      end
      default: begin
        pwr_next = ACR_PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pwr_reg      <= ACR_PWR_RUN;
      wake_cnt_reg <= 32'h0000_0000;
    end else begin
      pwr_reg      <= pwr_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // function outputs registered from the control bits
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      a_on_reg   <= 1'b1;
      b_on_reg   <= 1'b1;
      buf_on_reg <= 1'b1;
      ready_reg  <= 1'b1;
      a_fast_reg <= 1'b0;
      b_fast_reg <= 1'b0;
      a_slow_reg <= 1'b0;
      swing_reg  <= 1'b0;
      drive_reg  <= 1'b0;
      tuning_reg <= 1'b0;
    end else begin
      a_on_reg   <= pwr_next != ACR_PWR_STANDBY_REQUEST && pwr_next != ACR_PWR_OFF;
      b_on_reg   <= pwr_next != ACR_PWR_STANDBY_REQUEST && pwr_next != ACR_PWR_OFF;
      buf_on_reg <= pwr_next != ACR_PWR_OFF;
      ready_reg  <= pwr_next == ACR_PWR_RUN;
      b_fast_reg <= chan_b_high_freq_reg[`ACR_BIT_FAST_INPUT];
      a_fast_reg <= chan_a_high_freq_reg[`ACR_BIT_FAST_INPUT];
      a_slow_reg <= slow_mode_master_reg[`ACR_BIT_SLOW_MASTER] &&
                    chan_a_slow_mode_reg[`ACR_BIT_CHAN_A_SLOW];
      swing_reg  <= swing_control_enable_reg[1:0] == `ACR_SWING_ON;
      drive_reg  <= power_and_lvds_drive_reg[`ACR_BIT_CLKOUT_DRIVE];
      tuning_reg <= high_perf_tuning_a_reg[`ACR_BIT_FAST_TUNING];
    end
  end

  acr_offset_loop #(
    .WIDTH (WIDTH)
  ) u_loop_a (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_loop_on (loop_on),
    .i_hold    (hold),
    .i_tau     (tau),
    .i_shift   (a_shift),
    .i_sample  (i_chan_a_sample),
    .o_sample  (o_chan_a_sample)
  );

  acr_offset_loop #(
    .WIDTH (WIDTH)
  ) u_loop_b (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_loop_on (loop_on),
    .i_hold    (hold),
    .i_tau     (tau),
    .i_shift   (b_shift),
    .i_sample  (i_chan_b_sample),
    .o_sample  (o_chan_b_sample)
  );

  assign o_wb_dat                 = rdata_reg;
  assign o_wb_ack                 = ack_reg;
  assign o_chan_a_power_on        = a_on_reg;
  assign o_chan_b_power_on        = b_on_reg;
  assign o_out_buffers_on         = buf_on_reg;
  assign o_ready                  = ready_reg;
  assign o_chan_a_fast_input_mode = a_fast_reg;
  assign o_chan_b_fast_input_mode = b_fast_reg;
  assign o_chan_a_slow_on         = a_slow_reg;
  assign o_swing_ctrl_on          = swing_reg;
  assign o_clock_out_drive_level  = drive_reg;
  assign o_fast_sample_tuning_bit = tuning_reg;
endmodule

// File: acr_bank_assertions.sv
/*
  port checker of the converter configuration bank.
  assumes classic wishbone on i_ref_clk and synchronous active high reset.
*/
module acr_bank_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_chan_a_power_on,
  input wire logic        o_chan_b_power_on,
  input wire logic        o_out_buffers_on,
  input wire logic        o_ready,
  input wire logic        o_chan_a_fast_input_mode,
  input wire logic        o_chan_b_fast_input_mode,
  input wire logic        o_swing_ctrl_on
);
  wire logic take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire logic wr0  = take && i_wb_we && i_wb_sel[0];

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_ack_answer: assert property (take |=> o_wb_ack)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero while idle");
  chk_unmapped_read: assert property ((take && !i_wb_we && i_wb_adr == 8'h10) |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  chk_fast_a: assert property ((wr0 && i_wb_adr == 8'h58) |-> ##2 o_chan_a_fast_input_mode == $past(i_wb_dat[0], 2))
    else $error("chan a fast input mode wrong");
  chk_fast_b: assert property ((wr0 && i_wb_adr == 8'h4a) |-> ##2 o_chan_b_fast_input_mode == $past(i_wb_dat[0], 2))
    else $error("chan b fast input mode wrong");
  chk_swing_field: assert property ((wr0 && i_wb_adr == 8'hf1) |-> ##2 o_swing_ctrl_on == ($past(i_wb_dat[1:0], 2) == 2'b11))
    else $error("swing enable wrong");
  chk_power_off: assert property ((wr0 && i_wb_adr == 8'h45 && (i_wb_dat[7] || i_wb_dat[2])) |-> ##2 !(o_chan_a_power_on || o_chan_b_power_on || o_ready))
    else $error("channels not powered down");
  chk_pdn_buffers: assert property ((wr0 && i_wb_adr == 8'h45) |-> ##2 o_out_buffers_on == !$past(i_wb_dat[2], 2))
    else $error("output buffers state wrong");
  chk_ready_on: assert property (o_ready |-> o_chan_a_power_on && o_chan_b_power_on && o_out_buffers_on)
    else $error("ready while powered down");
endmodule

bind acr_bank acr_bank_checker u_acr_bank_checker (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_chan_a_power_on,
  .o_chan_b_power_on, .o_out_buffers_on, .o_ready, .o_chan_a_fast_input_mode,
  .o_chan_b_fast_input_mode, .o_swing_ctrl_on);

// File: acr_tb.sv
/*
  self-checking bench of the converter configuration bank.
  assumes acr_pkg, acr_defines.svh and the design modules are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 14;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h0;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
  logic [W-1:0] i_chan_a_sample = '0, i_chan_b_sample = '0, o_chan_a_sample, o_chan_b_sample;
  logic o_wb_ack, o_chan_a_power_on, o_chan_b_power_on, o_out_buffers_on, o_ready;
  logic o_chan_a_fast_input_mode, o_chan_b_fast_input_mode, o_chan_a_slow_on;
  logic o_swing_ctrl_on, o_clock_out_drive_level, o_fast_sample_tuning_bit;
  int err_count = 0;
  int checks = 0;
  logic [31:0] o_wb_dat_unused;
  logic [7:0] ofs [11] = '{8'h02, 8'h45, 8'h4a, 8'h58, 8'hbf, 8'hc1, 8'hcf, 8'hef, 8'hf1, 8'hf2, 8'h3d};
  logic [7:0] pat [11] = '{8'h40, 8'h40, 8'h01, 8'h01, 8'h7c, 8'h80, 8'h08, 8'h10, 8'h03, 8'h08, 8'h00};

  acr_bank #(.WIDTH(W), .WAKE_CYCLES(4)) u_acr_bank (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_chan_a_sample,
    .i_chan_b_sample, .o_chan_a_sample, .o_chan_b_sample, .o_chan_a_power_on,
    .o_chan_b_power_on, .o_out_buffers_on, .o_ready, .o_chan_a_fast_input_mode,
    .o_chan_b_fast_input_mode, .o_chan_a_slow_on, .o_swing_ctrl_on, .o_clock_out_drive_level,
    .o_fast_sample_tuning_bit);

  always #10 i_ref_clk = ~i_ref_clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic compare_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // a converging loop may settle one code off
  task automatic compare_code(input logic [W-1:0] got, input int exp, input string what);
    checks++;
    if ($isunknown(got) || int'(got) > exp + 1 || int'(got) < exp - 1) begin
      err_count++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [7:0] d,
                          input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    i_wb_sel <= s;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    r = o_wb_dat;
    if (n >= 20) compare_val(32'h0, 32'h1, "ack wait");
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_cycle(1'b1, a, d, 4'hf, r);
    repeat (3) @(posedge i_ref_clk);
  endtask

  task automatic wb_read(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    wb_cycle(1'b0, a, 8'h0, 4'hf, r);
    compare_val(r, {24'h0, exp}, what);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 12) begin
      @(posedge i_ref_clk);
      n++;
    end
    compare_val({31'h0, o_ready}, 32'h1, "ready after wake");
  endtask

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 11; k++) wb_read(ofs[k], 8'h00, "reset value");
    for (int k = 0; k < 11; k++) wb_write(ofs[k], pat[k]);
    for (int k = 0; k < 11; k++) wb_read(ofs[k], pat[k], "readback");
    compare_val({26'h0, o_chan_a_fast_input_mode, o_chan_b_fast_input_mode, o_chan_a_slow_on,
                 o_swing_ctrl_on, o_clock_out_drive_level, o_fast_sample_tuning_bit},
                32'h3f, "function bits");
    $display("test registers done");
    wb_write(8'hef, 8'h00);
    compare_val({31'h0, o_chan_a_slow_on}, 32'h0, "slow gated");
    for (int k = 0; k < 4; k += 3) begin
      wb_write(8'hf1, k[7:0]);
      compare_val({31'h0, o_swing_ctrl_on}, {31'h0, k == 3}, "swing field");
    end
    wb_write(8'h58, 8'h00);
    compare_val({31'h0, o_chan_a_fast_input_mode}, 32'h0, "fast a clear");
    wb_cycle(1'b1, 8'h4a, 8'h00, 4'he, o_wb_dat_unused);
    wb_read(8'h4a, 8'h01, "sel0 low ignored");
    wb_write(8'h10, 8'hff);
    wb_read(8'h10, 8'h00, "unmapped");
    wb_read(8'h60, 8'h0f, "status");
    $display("test modes done");
    wb_write(8'h45, 8'h80);
    compare_val({28'h0, o_chan_a_power_on, o_chan_b_power_on, o_out_buffers_on, o_ready},
                32'h2, "standby");
    wb_write(8'h45, 8'h00);
    wait_ready;
    wb_write(8'h45, 8'h84);
    compare_val({28'h0, o_chan_a_power_on, o_chan_b_power_on, o_out_buffers_on, o_ready},
                32'h0, "power down");
    wb_write(8'h45, 8'h00);
    wait_ready;
    compare_val({31'h0, o_out_buffers_on}, 32'h1, "buffers back");
    $display("test power done");
    @(posedge i_ref_clk);
    i_chan_a_sample <= 14'd1234;
    i_chan_b_sample <= 14'd4321;
    repeat (3) @(posedge i_ref_clk);
    compare_code(o_chan_a_sample, 1234, "loop off a");
    compare_code(o_chan_b_sample, 4321, "loop off b");
    wb_write(8'h3d, 8'h20);
    i_chan_a_sample <= 14'd5000;
    i_chan_b_sample <= 14'd11000;
    repeat (400) @(posedge i_ref_clk);
    compare_code(o_chan_a_sample, 8192 + 31, "pedestal a");
    compare_code(o_chan_b_sample, 8192 - 32, "pedestal b");
    wb_write(8'hcf, 8'h88);
    i_chan_a_sample <= 14'd5100;
    repeat (20) @(posedge i_ref_clk);
    compare_code(o_chan_a_sample, 8192 + 131, "frozen estimate");
    $display("test offset loop done");
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    give_verdict;
  end
endmodule
